// [bhs_top.sv]
// Purpose: Primary status, identity, cache line and latency bytes of the bridge header.
// Assumes: Config requests arrive as one-cycle strobes from the config unit.
// Notes:   The command half of the status dword is merged by the outer header mux.
`timescale 1ns/100ps
module bhs_top #(
  // Arbitrary value; the product revision is set at integration.
  parameter logic [7:0] REVISION = 8'h5a
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        cfg_req_i,
  input  wire logic        cfg_we_i,
  input  wire logic [11:0] cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic             cfg_ack_o,
  output logic [31:0]      cfg_rdata_o,
  input  wire logic        perr_resp_en_i,
  input  wire logic        serr_en_i,
  input  wire logic        ev_mdpe_i,
  input  wire logic        ev_sig_tabort_i,
  input  wire logic        ev_rcv_tabort_i,
  input  wire logic        ev_rcv_mabort_i,
  input  wire logic        ev_err_msg_i,
  input  wire logic        ev_poison_i,
  output logic [5:0]       status_flags_o
);

  // ==========================================================================
  // State

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  cls;
  } bhs_regs_s;

  bhs_regs_s         s_q;
  bhs_regs_s         s_d;

  bhs_pkg::bhs_reg_e sel_w;
  logic              rd_w;
  logic              wr_w;
  logic              rd_stat_w;
  logic              rd_ident_w;
  logic              rd_cache_w;
  logic              rd_none_w;
  logic              wr_stat_w;
  logic              cls_wr_w;
  logic [7:0]        wdata_lo_w;
  logic [31:0]       rd_word_w;

  bhs_flag_if flg ();

  // ==========================================================================
  // Request decode

  assign sel_w      = bhs_pkg::reg_decode(cfg_addr_i);
  assign rd_w       = cfg_req_i & ~cfg_we_i;
  assign wr_w       = cfg_req_i & cfg_we_i;
  assign rd_stat_w  = rd_w & (sel_w == bhs_pkg::REG_STATUS);
  assign rd_ident_w = rd_w & (sel_w == bhs_pkg::REG_IDENT);
  assign rd_cache_w = rd_w & (sel_w == bhs_pkg::REG_CACHE);
  assign rd_none_w  = rd_w & (sel_w == bhs_pkg::REG_NONE);
  assign wr_stat_w  = wr_w & (sel_w == bhs_pkg::REG_STATUS);
  // The cache line byte only takes a write with its own lane enabled.
  assign cls_wr_w   = wr_w & (sel_w == bhs_pkg::REG_CACHE) & cfg_be_i[0];  // [R14]
  assign wdata_lo_w = cfg_wdata_i[7:0];

  // Clear strobes go straight to the bank so a clear lands one edge after the write.
  assign flg.clr = wr_stat_w ? bhs_pkg::clear_vec(cfg_wdata_i, cfg_be_i)
                             : {bhs_pkg::NFLAG{1'b0}};  // [R11]

  // ==========================================================================
  // Read mux

  always_comb begin
    rd_word_w = 32'h0000_0000;
    unique case (sel_w)
      bhs_pkg::REG_STATUS: begin
        for (int i = 0; i < bhs_pkg::NFLAG; i++) begin
          rd_word_w[bhs_pkg::FLG_POS[i]] = flg.val[i];  // [R4] [R6] [R7] [R8] [R9] [R10]
        end
        // Forwarded interrupts are never folded in here.
        rd_word_w[bhs_pkg::BIT_INTX] = 1'b0;  // [R1]
        rd_word_w[bhs_pkg::BIT_CAPL] = bhs_pkg::CAPL_VAL;  // [R2]
        rd_word_w[bhs_pkg::BIT_66M]  = 1'b0;  // [R3]
        rd_word_w[bhs_pkg::BIT_FB2B] = 1'b0;  // [R3]
        rd_word_w[bhs_pkg::BIT_TIM_HI:bhs_pkg::BIT_TIM_LO] = 2'b00;  // [R3]
      end
      bhs_pkg::REG_IDENT: begin
        rd_word_w = {bhs_pkg::BASE_CLASS, bhs_pkg::SUB_CLASS,
                     bhs_pkg::PROG_IF, REVISION};  // [R12] [R13]
      end
      bhs_pkg::REG_CACHE: begin
        rd_word_w[15:8] = bhs_pkg::PLT_VAL;  // [R15]
        rd_word_w[7:0]  = s_q.cls;  // [R14]
      end
      bhs_pkg::REG_NONE: begin
        rd_word_w = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================================
  // Register update

  always_comb begin
    s_d     = s_q;
    s_d.ack = cfg_req_i;
    if (rd_w) begin
      s_d.rdata = rd_word_w;
    end
    // The stored size steers nothing; it is kept only for software.
    if (cls_wr_w) begin
      s_d.cls = wdata_lo_w;  // [R14]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q.ack   <= 1'b0;
      s_q.rdata <= bhs_pkg::RDATA_RST;
      s_q.cls   <= bhs_pkg::CLS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_ack_o      = s_q.ack;
  assign cfg_rdata_o    = s_q.rdata;
  assign status_flags_o = flg.val;

  // ==========================================================================
  // Submodules

  bhs_evt_qual u_qual (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .perr_resp_en_i  (perr_resp_en_i),
    .serr_en_i       (serr_en_i),
    .ev_mdpe_i       (ev_mdpe_i),
    .ev_sig_tabort_i (ev_sig_tabort_i),
    .ev_rcv_tabort_i (ev_rcv_tabort_i),
    .ev_rcv_mabort_i (ev_rcv_mabort_i),
    .ev_err_msg_i    (ev_err_msg_i),
    .ev_poison_i     (ev_poison_i),
    .flg             (flg.qual)
  );

  bhs_flag_bank u_bank (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .flg       (flg.bank)
  );

  // ==========================================================================
  // Assertions

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_land(int idx);
    ##2 flg.val[idx];
  endsequence

  sequence s_read_back;
    ##1 cfg_ack_o;
  endsequence

  property p_intx;
    rd_stat_w |-> s_read_back ##0 (cfg_rdata_o[19] == 1'b0);
  endproperty
  a_intx: assert property (p_intx) else $error("interrupt status bit not zero");  // [R1]

  property p_caplist;
    rd_stat_w |-> s_read_back ##0 (cfg_rdata_o[20] == 1'b1);
  endproperty
  a_caplist: assert property (p_caplist) else $error("capability list bit not one");  // [R2]

  property p_legacy;
    rd_stat_w |=> (cfg_rdata_o[21] == 1'b0) && (cfg_rdata_o[23] == 1'b0)
                  && (cfg_rdata_o[26:25] == 2'b00);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy status field not zero");  // [R3]

  property p_mdpe_set;
    ev_mdpe_i && perr_resp_en_i |-> s_land(0);
  endproperty
  a_mdpe_set: assert property (p_mdpe_set) else $error("parity flag not set");  // [R4]

  property p_mdpe_gate;
    $rose(flg.val[0]) |-> $past(perr_resp_en_i, 2) && $past(ev_mdpe_i, 2);
  endproperty
  a_mdpe_gate: assert property (p_mdpe_gate) else $error("parity flag set while off");  // [R5]

  property p_sta;
    ev_sig_tabort_i |-> s_land(1);
  endproperty
  a_sta: assert property (p_sta) else $error("signaled abort flag not set");  // [R6]

  property p_rta;
    ev_rcv_tabort_i |-> s_land(2);
  endproperty
  a_rta: assert property (p_rta) else $error("target abort flag not set");  // [R7]

  property p_rma;
    ev_rcv_mabort_i |-> s_land(3);
  endproperty
  a_rma: assert property (p_rma) else $error("master abort flag not set");  // [R8]

  property p_sse_set;
    ev_err_msg_i && serr_en_i |-> s_land(4);
  endproperty
  a_sse_set: assert property (p_sse_set) else $error("system error flag not set");  // [R9]

  property p_sse_gate;
    $rose(flg.val[4]) |-> $past(serr_en_i, 2);
  endproperty
  a_sse_gate: assert property (p_sse_gate) else $error("error flag set while off");  // [R17]

  property p_dpe;
    ev_poison_i |-> s_land(5);
  endproperty
  a_dpe: assert property (p_dpe) else $error("detected parity flag not set");  // [R10]

  property p_clear;
    wr_stat_w && cfg_be_i[3] && cfg_wdata_i[31] && !flg.set[5] |=> !flg.val[5];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear flag");  // [R11]

  property p_set_wins;
    flg.set[bhs_pkg::FLG_DPE] && flg.clr[bhs_pkg::FLG_DPE] |=> flg.val[bhs_pkg::FLG_DPE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost against clear");  // [R11]

  property p_ro_hold;
    flg.val[1] |=> flg.val[1];
  endproperty
  a_ro_hold: assert property (p_ro_hold) else $error("signaled abort flag fell");  // [R6]

  property p_ident;
    rd_ident_w |=> (cfg_rdata_o == {8'h06, 8'h04, 8'h00, REVISION});
  endproperty
  a_ident: assert property (p_ident) else $error("identity dword wrong");  // [R12]

  sequence s_cls_gap;
    cls_wr_w ##1 !cls_wr_w ##1 (rd_cache_w && !cls_wr_w);
  endsequence

  property p_cls;
    s_cls_gap |=> (cfg_rdata_o[7:0] == $past(wdata_lo_w, 3));
  endproperty
  a_cls: assert property (p_cls) else $error("cache line size not stored");  // [R14]

  property p_plt;
    rd_cache_w |=> (cfg_rdata_o[15:8] == 8'h00);
  endproperty
  a_plt: assert property (p_plt) else $error("latency timer byte not zero");  // [R15]

  property p_unmapped;
    rd_none_w |=> cfg_ack_o && (cfg_rdata_o == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_ack;
    cfg_req_i |=> cfg_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged");

  property p_ack_idle;
    !cfg_req_i |=> !cfg_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("acknowledge without request");

  property p_rdata_hold;
    !rd_w |=> $stable(cfg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  // The reset check must run while reset is high, so it opts out of the default disable.
  property p_reset_vals;
    disable iff (1'b0)
      rst_i |=> !cfg_ack_o && (cfg_rdata_o == 32'h0000_0000)
                && (flg.val == 6'h00) && (s_q.cls == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");  // [R14]

  property p_mdpe_off;
    !perr_resp_en_i |=> !flg.set[bhs_pkg::FLG_MDPE];
  endproperty
  a_mdpe_off: assert property (p_mdpe_off) else $error("parity set while off");  // [R5] [R16]

  property p_sse_off;
    !serr_en_i |=> !flg.set[bhs_pkg::FLG_SSE];
  endproperty
  a_sse_off: assert property (p_sse_off) else $error("error set while off");  // [R17]

  property p_dpe_any;
    ev_poison_i && !perr_resp_en_i |-> s_land(5);
  endproperty
  a_dpe_any: assert property (p_dpe_any) else $error("poison flag gated by enable");  // [R10]

  property p_sta_gate;
    $rose(flg.val[1]) |-> $past(ev_sig_tabort_i, 2);
  endproperty
  a_sta_gate: assert property (p_sta_gate) else $error("spurious signaled abort");  // [R6]

  property p_rta_gate;
    $rose(flg.val[2]) |-> $past(ev_rcv_tabort_i, 2);
  endproperty
  a_rta_gate: assert property (p_rta_gate) else $error("spurious target abort");  // [R7]

  property p_rma_gate;
    $rose(flg.val[3]) |-> $past(ev_rcv_mabort_i, 2);
  endproperty
  a_rma_gate: assert property (p_rma_gate) else $error("spurious master abort");  // [R8]

  property p_dpe_gate;
    $rose(flg.val[5]) |-> $past(ev_poison_i, 2);
  endproperty
  a_dpe_gate: assert property (p_dpe_gate) else $error("spurious poison flag");  // [R10]

  property p_rta_hold;
    flg.val[2] |=> flg.val[2];
  endproperty
  a_rta_hold: assert property (p_rta_hold) else $error("target abort flag fell");  // [R7]

  property p_rma_hold;
    flg.val[3] |=> flg.val[3];
  endproperty
  a_rma_hold: assert property (p_rma_hold) else $error("master abort flag fell");  // [R8]

  property p_flag_keep;
    !wr_stat_w |=> ((flg.val & $past(flg.val)) == $past(flg.val));
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost");  // [R11]

  property p_cls_keep;
    !cls_wr_w |=> $stable(s_q.cls);
  endproperty
  a_cls_keep: assert property (p_cls_keep) else $error("cache line size moved");  // [R14]

  property p_status_rsvd;
    rd_stat_w |=> (cfg_rdata_o[18:0] == 19'h0_0000) && !cfg_rdata_o[22];
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved bits set");

  property p_cache_rsvd;
    rd_cache_w |=> (cfg_rdata_o[31:16] == 16'h0000);
  endproperty
  a_cache_rsvd: assert property (p_cache_rsvd) else $error("cache dword upper half set");

endmodule : bhs_top

// [bhs_pkg.sv]
// Purpose: Shared constants, decode and field helpers for the bridge header status block.
// Assumes: Dword-aligned configuration accesses with byte addresses.
// Notes:   All offsets are byte addresses within configuration space.
// Operation
// R1: Interrupt-pending status bit always reads zero.
// R2: Capability-list bit reads one from reset.
// R3: Legacy speed and timing status fields read zero.
// R4: Requester parity error sets master parity flag.
// R5: Master parity flag stays clear when response disabled.
// R6: Completer-abort completion sent sets signaled abort flag.
// R7: Completer-abort completion received sets target abort flag.
// R8: Unsupported-request completion received sets master abort.
// R9: Error message sent with reporting enabled sets flag.
// R10: Poisoned packet received always sets detected parity flag.
// R11: Writing one clears clearable flags; set wins.
// R12: Revision byte is fixed read-only value.
// R13: Class code reads bridge base, sub, interface.
// R14: Cache line size is plain read-write byte.
// R15: Primary latency timer byte always reads zero.
// R16: Parity response enable gates parity flag action.
// R17: Error reporting enable gates system error flag.
package bhs_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IDENT  = 12'h008;
  localparam logic [11:0] OFS_CACHE  = 12'h00c;

  // ==========================================================================
  // Status field positions within the dword at the status offset
  localparam int BIT_INTX    = 19;
  localparam int BIT_CAPL    = 20;
  localparam int BIT_66M     = 21;
  localparam int BIT_FB2B    = 23;
  localparam int BIT_TIM_LO  = 25;
  localparam int BIT_TIM_HI  = 26;
  localparam int BIT_MDPE    = 24;
  localparam int BIT_STA     = 27;
  localparam int BIT_RTA     = 28;
  localparam int BIT_RMA     = 29;
  localparam int BIT_SSE     = 30;
  localparam int BIT_DPE     = 31;

  // ==========================================================================
  // Sticky flag bank layout
  localparam int NFLAG    = 6;
  localparam int FLG_MDPE = 0;
  localparam int FLG_STA  = 1;
  localparam int FLG_RTA  = 2;
  localparam int FLG_RMA  = 3;
  localparam int FLG_SSE  = 4;
  localparam int FLG_DPE  = 5;
  localparam int FLG_POS [NFLAG] = '{BIT_MDPE, BIT_STA, BIT_RTA, BIT_RMA, BIT_SSE, BIT_DPE};
  localparam logic [NFLAG-1:0] FLG_W1C_MASK = 6'h31;
  localparam logic [NFLAG-1:0] FLG_RST      = 6'h00;

  // ==========================================================================
  // Fixed values and reset values
  localparam logic       CAPL_VAL   = 1'b1;
  localparam logic [7:0] BASE_CLASS = 8'h06;
  localparam logic [7:0] SUB_CLASS  = 8'h04;
  localparam logic [7:0] PROG_IF    = 8'h00;
  localparam logic [7:0] PLT_VAL    = 8'h00;
  localparam logic [7:0] CLS_RST    = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {REG_NONE, REG_STATUS, REG_IDENT, REG_CACHE} bhs_reg_e;

  function automatic bhs_reg_e reg_decode(input logic [11:0] a);
    logic [11:0] dw;
    dw = {a[11:2], 2'b00};
    if (dw == OFS_STATUS) return REG_STATUS;
    if (dw == OFS_IDENT) return REG_IDENT;
    if (dw == OFS_CACHE) return REG_CACHE;
    return REG_NONE;
  endfunction : reg_decode

  function automatic logic [NFLAG-1:0] clear_vec(input logic [31:0] d, input logic [3:0] be);
    logic [NFLAG-1:0] c;
    c = '0;
    for (int i = 0; i < NFLAG; i++) begin
      c[i] = d[FLG_POS[i]] & be[FLG_POS[i] / 8];
    end
    return c;
  endfunction : clear_vec

endpackage : bhs_pkg

// [bhs_flag_if.sv]
// Purpose: Carries flag set, clear and value vectors between block modules.
// Assumes: All users run on the same core clock.
// Notes:   Set and clear are single-cycle pulses.
`timescale 1ns/100ps
interface bhs_flag_if;
  logic [bhs_pkg::NFLAG-1:0] set;
  logic [bhs_pkg::NFLAG-1:0] clr;
  logic [bhs_pkg::NFLAG-1:0] val;

  modport qual (output set);
  modport bank (input set, input clr, output val);
  modport regs (output clr, input val, input set);
endinterface : bhs_flag_if

// [bhs_evt_qual.sv]
// Purpose: Qualifies datapath error events with the command enables.
// Assumes: Events and enables come from logic on the core clock.
// Notes:   One register stage; a flag lands two edges after its event.
`timescale 1ns/100ps
module bhs_evt_qual (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_i,
  input  wire logic  perr_resp_en_i,
  input  wire logic  serr_en_i,
  input  wire logic  ev_mdpe_i,
  input  wire logic  ev_sig_tabort_i,
  input  wire logic  ev_rcv_tabort_i,
  input  wire logic  ev_rcv_mabort_i,
  input  wire logic  ev_err_msg_i,
  input  wire logic  ev_poison_i,
  bhs_flag_if.qual   flg
);
  typedef struct packed {
    logic [bhs_pkg::NFLAG-1:0] set;
  } bhs_qual_s;

  bhs_qual_s s_q;
  bhs_qual_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.set[bhs_pkg::FLG_MDPE] = ev_mdpe_i & perr_resp_en_i;  // [R4] [R5] [R16]
    s_d.set[bhs_pkg::FLG_STA]  = ev_sig_tabort_i;             // [R6]
    s_d.set[bhs_pkg::FLG_RTA]  = ev_rcv_tabort_i;             // [R7]
    s_d.set[bhs_pkg::FLG_RMA]  = ev_rcv_mabort_i;             // [R8]
    s_d.set[bhs_pkg::FLG_SSE]  = ev_err_msg_i & serr_en_i;    // [R9] [R17]
    s_d.set[bhs_pkg::FLG_DPE]  = ev_poison_i;                 // [R10]
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q.set <= bhs_pkg::FLG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign flg.set = s_q.set;
endmodule : bhs_evt_qual

// [bhs_flag_bank.sv]
// Purpose: Sticky status flags with write-one-to-clear on selected bits.
// Assumes: Set and clear are one-cycle pulses on the core clock.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/100ps
module bhs_flag_bank (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_i,
  bhs_flag_if.bank   flg
);
  typedef struct packed {
    logic [bhs_pkg::NFLAG-1:0] val;
  } bhs_bank_s;

  bhs_bank_s                 s_q;
  bhs_bank_s                 s_d;
  logic [bhs_pkg::NFLAG-1:0] nxt;

  for (genvar i = 0; i < bhs_pkg::NFLAG; i++) begin : g_flag
    // Bits outside the clear mask only fall at reset.
    assign nxt[i] = flg.set[i] |
                    (s_q.val[i] & ~(flg.clr[i] & bhs_pkg::FLG_W1C_MASK[i]));  // [R11]
  end

  always_comb begin
    s_d     = s_q;
    s_d.val = nxt;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q.val <= bhs_pkg::FLG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign flg.val = s_q.val;
endmodule : bhs_flag_bank

// [bhs_rc_model.sv]
// Purpose: Root complex model that issues configuration reads and writes.
// Assumes: One request strobe per call, answered one cycle after it is taken.
// Notes:   Idle lines carry the inverse of the last request so stale data never matches.
`timescale 1ns/100ps
module bhs_rc_model (
  input  wire logic        ref_clk_i,
  output logic             cfg_req_o,
  output logic             cfg_we_o,
  output logic [11:0]      cfg_addr_o,
  output logic [3:0]       cfg_be_o,
  output logic [31:0]      cfg_wdata_o,
  input  wire logic        cfg_ack_i,
  input  wire logic [31:0] cfg_rdata_i
);
  initial begin
    cfg_req_o   = 1'b0;
    cfg_we_o    = 1'b0;
    cfg_addr_o  = 12'h000;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = 32'h0000_0000;
  end

  // ==========================================================================
  // Request sequencing
  // The strobe is a single-cycle pulse, so holding it would start a second request.
  task automatic xfer(input logic we, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    @(negedge ref_clk_i);
    cfg_req_o   = 1'b1;
    cfg_we_o    = we;
    cfg_addr_o  = a;
    cfg_be_o    = be;
    cfg_wdata_o = wd;
    @(negedge ref_clk_i);
    ack         = cfg_ack_i;
    rd          = cfg_rdata_i;
    cfg_req_o   = 1'b0;
    cfg_we_o    = ~we;
    cfg_addr_o  = ~a;
    cfg_be_o    = ~be;
    cfg_wdata_o = ~wd;
  endtask : xfer
endmodule : bhs_rc_model

// [tb.sv]
// Purpose: Self-checking bench for the bridge header status block.
// Assumes: Inputs change at the falling clock edge; flags land two edges after events.
// Notes:   Expected values are built from field positions, not from design outputs.
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("wrong value at %0t: got %h exp %h", $time, g, e); \
    end \
  end
module tb;
  localparam logic [7:0] REV = 8'h3c;

  logic        ref_clk_i;
  logic        rst_i;
  logic        perr_en;
  logic        serr_en;
  logic [5:0]  ev;
  logic [5:0]  flags;
  logic [5:0]  exp_f;
  logic        req;
  logic        we;
  logic [11:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  int          bad_count;
  int          compares;
  int          cycles;

  bhs_top #(.REVISION(REV)) dut_u (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .cfg_req_i       (req),
    .cfg_we_i        (we),
    .cfg_addr_i      (addr),
    .cfg_be_i        (be),
    .cfg_wdata_i     (wdata),
    .cfg_ack_o       (ack),
    .cfg_rdata_o     (rdata),
    .perr_resp_en_i  (perr_en),
    .serr_en_i       (serr_en),
    .ev_mdpe_i       (ev[0]),
    .ev_sig_tabort_i (ev[1]),
    .ev_rcv_tabort_i (ev[2]),
    .ev_rcv_mabort_i (ev[3]),
    .ev_err_msg_i    (ev[4]),
    .ev_poison_i     (ev[5]),
    .status_flags_o  (flags)
  );

  bhs_rc_model rc_u (
    .ref_clk_i   (ref_clk_i),
    .cfg_req_o   (req),
    .cfg_we_o    (we),
    .cfg_addr_o  (addr),
    .cfg_be_o    (be),
    .cfg_wdata_o (wdata),
    .cfg_ack_i   (ack),
    .cfg_rdata_i (rdata)
  );

  // ==========================================================================
  // Clock, watchdog and verdict
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Access and event helpers
  function automatic logic [31:0] st_exp(input logic [5:0] f);
    return {f[5], f[4], f[3], f[2], f[1], 2'b00, f[0], 8'h10, 16'h0000};
  endfunction : st_exp

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic        k;
    logic [31:0] d;
    rc_u.xfer(1'b0, a, 4'hf, 32'h0000_0000, k, d);
    `CHK(k, 1'b1)
    `CHK(d, e)
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    logic        k;
    logic [31:0] r;
    rc_u.xfer(1'b1, a, b, d, k, r);
    `CHK(k, 1'b1)
  endtask : wr

  // A flag is visible two edges after the event cycle.
  task automatic pulse(input int i);
    @(negedge ref_clk_i);
    ev[i] = 1'b1;
    @(negedge ref_clk_i);
    ev[i] = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask : pulse

  // ==========================================================================
  // Test sequence
  initial begin
    rst_i     = 1'b1;
    perr_en   = 1'b0;
    serr_en   = 1'b0;
    ev        = 6'h00;
    bad_count = 0;
    compares  = 0;
    cycles    = 0;
    exp_f     = 6'h00;
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    rd(12'h004, st_exp(6'h00));
    rd(12'h008, {8'h06, 8'h04, 8'h00, REV});
    rd(12'h00c, 32'h0000_0000);
    rd(12'h010, 32'h0000_0000);
    wr(12'h00c, 4'hf, 32'hffff_ffa5);
    rd(12'h00c, 32'h0000_00a5);
    wr(12'h00c, 4'he, 32'h0000_0033);
    rd(12'h00c, 32'h0000_00a5);
    wr(12'h008, 4'hf, 32'hffff_ffff);
    rd(12'h008, {8'h06, 8'h04, 8'h00, REV});
    wr(12'h004, 4'hf, 32'h7fff_ffff);
    rd(12'h004, st_exp(6'h00));
    pulse(0);
    pulse(4);
    `CHK(flags, 6'h00)
    pulse(5);
    exp_f = 6'h20;
    `CHK(flags, exp_f)
    perr_en = 1'b1;
    serr_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      exp_f[i] = 1'b1;
      `CHK(flags, exp_f)
      rd(12'h004, st_exp(exp_f));
    end
    // Software clears only with lane 3 enabled and a one in the flag position.
    wr(12'h004, 4'h7, 32'hffff_ffff);
    `CHK(flags, 6'h3f)
    wr(12'h004, 4'hf, 32'h0000_0000);
    `CHK(flags, 6'h3f)
    wr(12'h004, 4'hf, 32'hffff_ffff);
    exp_f = 6'h0e;
    rd(12'h004, st_exp(exp_f));
    pulse(0);
    pulse(5);
    `CHK(flags, 6'h2f)
    @(negedge ref_clk_i);
    ev[5] = 1'b1;
    fork
      wr(12'h004, 4'h8, 32'hff00_0000);
      begin
        @(negedge ref_clk_i);
        ev[5] = 1'b0;
      end
    join
    @(negedge ref_clk_i);
    `CHK(flags, 6'h2e)
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    `CHK(flags, 6'h00)
    rd(12'h00c, 32'h0000_0000);
    rd(12'h004, st_exp(6'h00));
    test_done();
  end
endmodule : tb
